// *** rtl/ctc_top.sv ***
// Capture timer configuration registers, event edge control and counter.
`timescale 1ns/1ns

// Operation
// - Standby run keeps timer going in standby; ignored with companion clock.
// - Synchronised restart clears counter on companion restart, not with halved clock.
// - Clock select picks undivided, halved or companion clock; other code reserved.
// - Enable bit activates the timer; while clear the timer stays inactive.
// - Single shot output rises after synchronised start, or at event when asynchronous.
// - Initial level sets waveform start level, ignored in PWM and single shot.
// - Waveform output enable lets the waveform override the port value on the pin.
// - Counting mode field selects one of eight modes in fixed order.
// - Filter bit turns on noise cancellation for the capture event input.
// - Periodic and PWM modes ignore all events and edges.
// - Time-out start/stop by edge; single shot starts on rising or either edge.
// - Capture mode captures and signals on the selected edge only.
// - Frequency mode captures, clears and restarts, signals on selected edge.
// - Width mode: selected edge clears and restarts, opposite edge captures and signals.
// - Combined mode: restart, opposite edge capture, next selected edge stops and signals.
// - Capture event input enable lets events act; otherwise events do nothing.
// - Filter passes a level only after four agreeing samples.
module ctc_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ctc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic event_in,
	input wire logic companion_tick,
	input wire logic companion_restart,
	input wire logic standby_sleep,
	input wire logic [ctc_pkg::CNT_W-1:0] top_value,
	input wire logic port_out_value,
	output logic pin_out,
	output logic pin_override,
	output logic [ctc_pkg::CNT_W-1:0] count_value,
	output logic [ctc_pkg::CNT_W-1:0] capture_value,
	output logic capture_event,
	output logic running
);
	import ctc_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] main_ctrl_reg, mode_ctrl_reg, event_ctrl_reg, rdata_reg;
	logic [CNT_W-1:0] cnt_reg, cnt_next, cap_reg, cap_next;
	logic run_reg, run_next, run_prev_reg, irq_reg, irq_next, wave_reg, wave_next;
	logic pin_reg, pin_ovr_reg;
	ctc_fw_state_t fw_reg, fw_next;
	logic enable, standby_run, sync_restart, asynchronous_start_start, init_level, wave_en;
	logic capture_on_event_mode_ei, edge_sel, prev_level_reg, active, tick_ok, restart_ok, ev_ok;
	logic rise, fall, sel_edge, opp_edge, trigger, init_eff;
	logic [1:0] clock_select;
	logic [2:0] mode;

	// Modes whose counter free-runs while the timer is enabled.
	function automatic logic mode_free_runs(input logic [2:0] m);
		return (m == MODE_PERIODIC) || (m == MODE_CAPTURE) || (m == MODE_FREQ) ||
			(m == MODE_WIDTH) || (m == MODE_EIGHT_BIT_PWM_MODE);
	endfunction

	// Modes that take no action on events.
	function automatic logic mode_deaf(input logic [2:0] m);
		return (m == MODE_PERIODIC) || (m == MODE_EIGHT_BIT_PWM_MODE);
	endfunction

	ctc_core_if cif ();

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	// Split the control bytes into their fields.
	assign enable = main_ctrl_reg[BIT_ENABLE];
	assign clock_select = main_ctrl_reg[BIT_CLOCK_SELECT_HI:BIT_CLOCK_SELECT_LO];
	assign sync_restart = main_ctrl_reg[BIT_SYNC_RESTART];
	assign standby_run = main_ctrl_reg[BIT_STANDBY_RUN];
	assign mode = mode_ctrl_reg[BIT_MODE_HI:BIT_MODE_LO];
	assign wave_en = mode_ctrl_reg[BIT_WAVE_EN];
	assign init_level = mode_ctrl_reg[BIT_INIT_LEVEL];
	assign asynchronous_start_start = mode_ctrl_reg[BIT_ASYNCHRONOUS_START_START];
	assign capture_on_event_mode_ei = event_ctrl_reg[BIT_CAPTURE_ON_EVENT_MODE_EI];
	assign edge_sel = event_ctrl_reg[BIT_EDGE];

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	// Writes store only the defined bits of each control byte.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			main_ctrl_reg <= RESET_BYTE;
			mode_ctrl_reg <= RESET_BYTE;
			event_ctrl_reg <= RESET_BYTE;
		end else if (reg_wr) begin
			if (reg_addr == OFS_MAIN_CTRL) begin
				main_ctrl_reg <= reg_wdata & MASK_MAIN_CTRL;
			end else if (reg_addr == OFS_MODE_CTRL) begin
				mode_ctrl_reg <= reg_wdata & MASK_MODE_CTRL;
			end else if (reg_addr == OFS_EVENT_CTRL) begin
				event_ctrl_reg <= reg_wdata & MASK_EVENT_CTRL;
			end
		end
	end

	// Read data stands for the one cycle after the read strobe.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_reg <= RESET_BYTE;
		end else if (!reg_rd) begin
			rdata_reg <= RESET_BYTE;
		end else if (reg_addr == OFS_MAIN_CTRL) begin
			rdata_reg <= main_ctrl_reg;
		end else if (reg_addr == OFS_MODE_CTRL) begin
			rdata_reg <= mode_ctrl_reg;
		end else if (reg_addr == OFS_EVENT_CTRL) begin
			rdata_reg <= event_ctrl_reg;
		end else if (reg_addr == OFS_STATUS) begin
			rdata_reg <= RESET_BYTE | ({7'h00, run_reg} << BIT_RUN);
		end else begin
			rdata_reg <= RESET_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// Event filter, clock generator and edge detection
	// ----------------------------------------------------------------
	// Drive the helper modules through the shared interface.
	assign cif.raw_event = event_in;
	assign cif.filter_en = event_ctrl_reg[BIT_FILTER];
	assign cif.clock_select = clock_select;
	assign cif.companion_tick = companion_tick;

	ctc_event_filter u_filter (.mclk(mclk), .rst(rst), .f(cif.filt));
	ctc_clock_gen u_clock (.mclk(mclk), .rst(rst), .c(cif.clkg));

	// Remember the last filtered level and the last run state.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_level_reg <= 1'b0;
			run_prev_reg <= 1'b0;
		end else begin
			prev_level_reg <= cif.event_level;
			run_prev_reg <= run_reg;
		end
	end

	// Qualify ticks, restarts and events by enable, standby and mode.
	assign active = enable && (!standby_sleep || standby_run ||
		(clock_select == CLK_COMPANION));
	assign tick_ok = active && cif.count_tick;
	assign restart_ok = active && sync_restart && (clock_select != CLK_HALVED) &&
		companion_restart;
	assign ev_ok = active && capture_on_event_mode_ei && !mode_deaf(mode);
	assign rise = cif.event_level && !prev_level_reg;
	assign fall = !cif.event_level && prev_level_reg;
	assign sel_edge = edge_sel ? fall : rise;
	assign opp_edge = edge_sel ? rise : fall;
	assign trigger = edge_sel ? (rise || fall) : rise;
	assign init_eff = ((mode == MODE_SINGLE) || (mode == MODE_EIGHT_BIT_PWM_MODE)) ? 1'b0 : init_level;

	// ----------------------------------------------------------------
	// Counter, capture and waveform next state
	// ----------------------------------------------------------------
	// Counting first, then companion restart, then event actions on top.
	always_comb begin
		cnt_next = cnt_reg;
		cap_next = cap_reg;
		run_next = run_reg;
		irq_next = 1'b0;
		fw_next = fw_reg;
		wave_next = wave_reg;
		if (!enable) begin
			cnt_next = CNT_ZERO;
			run_next = 1'b0;
			fw_next = CTC_FW_IDLE;
			wave_next = init_eff;
		end else if (active) begin
			if (mode_free_runs(mode)) begin
				run_next = 1'b1;
			end
			if (tick_ok && run_reg) begin
				case (mode)
					MODE_PERIODIC: begin
						if (cnt_reg == top_value) begin
							cnt_next = CNT_ZERO;
							irq_next = 1'b1;
						end else begin
							cnt_next = cnt_reg + CNT_ONE;
						end
					end
					MODE_TIMEOUT, MODE_SINGLE: begin
						if (cnt_reg == top_value) begin
							run_next = 1'b0;
							irq_next = 1'b1;
							if (mode == MODE_SINGLE) begin
								wave_next = 1'b0;
							end
						end else begin
							cnt_next = cnt_reg + CNT_ONE;
						end
					end
					MODE_EIGHT_BIT_PWM_MODE: begin
						if (cnt_reg[7:0] == top_value[7:0]) begin
							cnt_next = CNT_ZERO;
							irq_next = 1'b1;
						end else begin
							cnt_next = cnt_reg + CNT_ONE;
						end
					end
					default: begin
						cnt_next = cnt_reg + CNT_ONE;
					end
				endcase
			end
			if (mode == MODE_EIGHT_BIT_PWM_MODE) begin
				wave_next = cnt_next[7:0] < top_value[15:8];
			end
			if (restart_ok) begin
				cnt_next = CNT_ZERO;
			end
			if (mode == MODE_SINGLE && !asynchronous_start_start && run_reg && !run_prev_reg) begin
				wave_next = 1'b1;
			end
			if (ev_ok) begin
				case (mode)
					MODE_TIMEOUT: begin
						if (sel_edge) begin
							run_next = 1'b1;
						end else if (opp_edge) begin
							run_next = 1'b0;
						end
					end
					MODE_CAPTURE: begin
						if (sel_edge) begin
							cap_next = cnt_reg;
							irq_next = 1'b1;
						end
					end
					MODE_FREQ: begin
						if (sel_edge) begin
							cap_next = cnt_reg;
							cnt_next = CNT_ZERO;
							irq_next = 1'b1;
						end
					end
					MODE_WIDTH: begin
						if (sel_edge) begin
							cnt_next = CNT_ZERO;
						end else if (opp_edge) begin
							cap_next = cnt_reg;
							irq_next = 1'b1;
						end
					end
					MODE_FREQ_WIDTH: begin
						case (fw_reg)
							CTC_FW_IDLE: begin
								if (sel_edge) begin
									cnt_next = CNT_ZERO;
									run_next = 1'b1;
									fw_next = CTC_FW_MEASURE;
								end
							end
							CTC_FW_MEASURE: begin
								if (opp_edge) begin
									cap_next = cnt_reg;
									fw_next = CTC_FW_CAPTURED;
								end
							end
							default: begin
								if (sel_edge) begin
									run_next = 1'b0;
									irq_next = 1'b1;
									fw_next = CTC_FW_IDLE;
								end
							end
						endcase
					end
					MODE_SINGLE: begin
						if (trigger && !run_reg) begin
							cnt_next = CNT_ZERO;
							run_next = 1'b1;
							if (asynchronous_start_start) begin
								wave_next = 1'b1;
							end
						end
					end
					default: begin
						run_next = run_next;
					end
				endcase
			end
		end
	end

	// Counter, capture, run and measurement state.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= CNT_ZERO;
			cap_reg <= CNT_ZERO;
			run_reg <= 1'b0;
			irq_reg <= 1'b0;
			fw_reg <= CTC_FW_IDLE;
		end else begin
			cnt_reg <= cnt_next;
			cap_reg <= cap_next;
			run_reg <= run_next;
			irq_reg <= irq_next;
			fw_reg <= fw_next;
		end
	end

	// Waveform and pin override; the port value passes while the override is off.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wave_reg <= 1'b0;
			pin_reg <= 1'b0;
			pin_ovr_reg <= 1'b0;
		end else begin
			wave_reg <= wave_next;
			pin_reg <= wave_en ? wave_reg : port_out_value;
			pin_ovr_reg <= wave_en;
		end
	end

	assign reg_rdata = rdata_reg;
	assign pin_out = pin_reg;
	assign pin_override = pin_ovr_reg;
	assign count_value = cnt_reg;
	assign capture_value = cap_reg;
	assign capture_event = irq_reg;
	assign running = run_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_disable_idle: assert property (@(posedge mclk) disable iff (rst)
		!enable |=> (!running && count_value == CNT_ZERO))
		else $error("disabled timer still counting");
	a_deaf_modes: assert property (@(posedge mclk) disable iff (rst)
		(capture_value != $past(capture_value)) |-> !mode_deaf($past(mode)))
		else $error("capture taken in a mode that ignores events");
	a_capture_edge: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_CAPTURE && sel_edge)
		|=> (capture_event && capture_value == $past(cnt_reg)))
		else $error("capture on selected edge missing");
	a_freq_restart: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_FREQ && sel_edge) |=> (count_value == CNT_ZERO && capture_event))
		else $error("frequency edge did not restart counter");
	a_width_clear: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_WIDTH && sel_edge) |=> (count_value == CNT_ZERO && !capture_event))
		else $error("width restart edge misbehaved");
	a_event_gate: assert property (@(posedge mclk) disable iff (rst)
		(!capture_on_event_mode_ei && mode == MODE_CAPTURE) |=> !capture_event)
		else $error("event acted while capture input disabled");
	a_timeout_start: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_TIMEOUT && sel_edge) |=> running)
		else $error("time-out start edge did not start counter");
	a_asynchronous_start_fast: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_SINGLE && asynchronous_start_start && trigger && !run_reg) |=> wave_reg)
		else $error("asynchronous start did not raise output at once");
	a_sync_delay: assert property (@(posedge mclk) disable iff (rst)
		(ev_ok && mode == MODE_SINGLE && !asynchronous_start_start && trigger && !run_reg && !wave_reg)
		##1 (active && mode == MODE_SINGLE && !asynchronous_start_start) |-> !wave_reg ##1 wave_reg)
		else $error("synchronised start output timing wrong");
	a_pin_port: assert property (@(posedge mclk) disable iff (rst)
		(!wave_en [*2]) |-> (pin_out == $past(port_out_value) && !pin_override))
		else $error("waveform reached the pin while disabled");
	a_sync_restart: assert property (@(posedge mclk) disable iff (rst)
		(restart_ok && !ev_ok) |=> count_value == CNT_ZERO)
		else $error("companion restart did not clear counter");
	a_standby_halt: assert property (@(posedge mclk) disable iff (rst)
		(enable && standby_sleep && !standby_run && clock_select != CLK_COMPANION)
		|=> (count_value == $past(count_value)))
		else $error("timer counted in standby without standby run");
endmodule

// *** rtl/ctc_pkg.sv ***
// Constants shared by the capture timer configuration and event control block.
package ctc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_MAIN_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_EVENT_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] MASK_MAIN_CTRL = 8'h57;
	localparam logic [7:0] MASK_MODE_CTRL = 8'h77;
	localparam logic [7:0] MASK_EVENT_CTRL = 8'h51;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_ENABLE = 0;
	localparam int BIT_CLOCK_SELECT_LO = 1;
	localparam int BIT_CLOCK_SELECT_HI = 2;
	localparam int BIT_SYNC_RESTART = 4;
	localparam int BIT_STANDBY_RUN = 6;
	localparam int BIT_MODE_LO = 0;
	localparam int BIT_MODE_HI = 2;
	localparam int BIT_WAVE_EN = 4;
	localparam int BIT_INIT_LEVEL = 5;
	localparam int BIT_ASYNCHRONOUS_START_START = 6;
	localparam int BIT_CAPTURE_ON_EVENT_MODE_EI = 0;
	localparam int BIT_EDGE = 4;
	localparam int BIT_FILTER = 6;
	localparam int BIT_RUN = 0;

	// ----------------------------------------------------------------
	// Clock select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CLK_UNDIVIDED = 2'h0;
	localparam logic [1:0] CLK_HALVED = 2'h1;
	localparam logic [1:0] CLK_RESERVED = 2'h2;
	localparam logic [1:0] CLK_COMPANION = 2'h3;

	// ----------------------------------------------------------------
	// Counting modes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_PERIODIC = 3'h0;
	localparam logic [2:0] MODE_TIMEOUT = 3'h1;
	localparam logic [2:0] MODE_CAPTURE = 3'h2;
	localparam logic [2:0] MODE_FREQ = 3'h3;
	localparam logic [2:0] MODE_WIDTH = 3'h4;
	localparam logic [2:0] MODE_FREQ_WIDTH = 3'h5;
	localparam logic [2:0] MODE_SINGLE = 3'h6;
	localparam logic [2:0] MODE_EIGHT_BIT_PWM_MODE = 3'h7;

	// ----------------------------------------------------------------
	// Counter and filter
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam int FILT_DEPTH = 4;

	// States of the combined frequency and width measurement.
	typedef enum logic [1:0] {
		CTC_FW_IDLE,
		CTC_FW_MEASURE,
		CTC_FW_CAPTURED
	} ctc_fw_state_t;
endpackage

// *** rtl/ctc_core_if.sv ***
// Interface joining the timer core to its event filter and clock generator.
`timescale 1ns/1ns
interface ctc_core_if;
	logic raw_event;
	logic filter_en;
	logic event_level;
	logic [1:0] clock_select;
	logic companion_tick;
	logic count_tick;

	modport filt (input raw_event, input filter_en, output event_level);
	modport clkg (input clock_select, input companion_tick, output count_tick);
	modport core (output raw_event, output filter_en, output clock_select,
		output companion_tick, input event_level, input count_tick);
endinterface

// *** rtl/ctc_event_filter.sv ***
// Noise filter that passes an event level once four samples agree.
`timescale 1ns/1ns
module ctc_event_filter (
	input wire logic mclk,
	input wire logic rst,
	ctc_core_if.filt f
);
	import ctc_pkg::*;

	logic [FILT_DEPTH-1:0] hist_reg;
	logic level_reg;

	// ----------------------------------------------------------------
	// Sample history and stable level
	// ----------------------------------------------------------------
	// Shift the raw event into the history every clock.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hist_reg <= '0;
		end else begin
			hist_reg <= {hist_reg[FILT_DEPTH-2:0], f.raw_event};
		end
	end

	// With the filter on, the level moves only when the whole history agrees.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_reg <= 1'b0;
		end else if (!f.filter_en) begin
			level_reg <= f.raw_event;
		end else if (&hist_reg) begin
			level_reg <= 1'b1;
		end else if (~|hist_reg) begin
			level_reg <= 1'b0;
		end
	end

	assign f.event_level = level_reg;

	a_filter_agree: assert property (@(posedge mclk) disable iff (rst)
		($past(f.filter_en) && (level_reg != $past(level_reg)))
		|-> ($past(hist_reg) == {FILT_DEPTH{level_reg}}))
		else $error("filtered level moved without four agreeing samples");
endmodule

// *** rtl/ctc_clock_gen.sv ***
// Count tick generator for the undivided, halved and companion clocks.
`timescale 1ns/1ns
module ctc_clock_gen (
	input wire logic mclk,
	input wire logic rst,
	ctc_core_if.clkg c
);
	import ctc_pkg::*;

	logic half_reg;

	// Toggle once per clock to give a tick on every second edge.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
		end
	end

	// Pick the tick; the reserved code gives no tick at all.
	always_comb begin
		if (c.clock_select == CLK_UNDIVIDED) begin
			c.count_tick = 1'b1;
		end else if (c.clock_select == CLK_HALVED) begin
			c.count_tick = half_reg;
		end else if (c.clock_select == CLK_COMPANION) begin
			c.count_tick = c.companion_tick;
		end else begin
			c.count_tick = 1'b0;
		end
	end

	a_halved_rate: assert property (@(posedge mclk) disable iff (rst)
		(c.clock_select == CLK_HALVED && c.count_tick) ##1 (c.clock_select == CLK_HALVED)
		|-> !c.count_tick)
		else $error("halved clock ticked on two edges in a row");
endmodule

// *** verif/ctc_event_net.sv ***
// Behavioural event network and companion timer driving the capture timer.
`timescale 1ns/1ns
module ctc_event_net (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ev_req,
	input wire logic tick_req,
	input wire logic restart_req,
	output logic event_in,
	output logic companion_tick,
	output logic companion_restart
);
	logic phase_reg;

	// Registered outputs hold each event level for a whole cycle; ticks come every other cycle.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			event_in <= 1'b0;
			phase_reg <= 1'b0;
			companion_tick <= 1'b0;
			companion_restart <= 1'b0;
		end else begin
			event_in <= ev_req;
			phase_reg <= ~phase_reg;
			companion_tick <= tick_req & phase_reg;
			companion_restart <= restart_req;
		end
	end
endmodule

// *** verif/capture_timer_config_control_test.sv ***
// Self-checking testbench for the capture timer configuration block.
`timescale 1ns/1ns
module capture_timer_config_control_test;
	import ctc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ev_req = 1'b0, tick_req = 1'b0, restart_req = 1'b0;
	logic standby_sleep = 1'b0, port_out_value = 1'b0;
	logic [15:0] top_value = 16'hffff;
	logic event_in, companion_tick, companion_restart, pin_out, pin_override, capture_event, running;
	logic [7:0] reg_rdata;
	logic [15:0] count_value, capture_value, c0;
	int err_count = 0, tests_run = 0, caps = 0, cyc = 0, n = 0;

	ctc_event_net net (.mclk, .rst, .ev_req, .tick_req, .restart_req, .event_in,
		.companion_tick, .companion_restart);
	ctc_top dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_in,
		.companion_tick, .companion_restart, .standby_sleep, .top_value, .port_out_value,
		.pin_out, .pin_override, .count_value, .capture_value, .capture_event, .running);

	// Clock, capture pulse counter and hang guard.
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		if (capture_event === 1'b1) caps++;
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test;
		end
	end

	task end_of_test;
		if (err_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	// Drives an event level, then waits k cycles and settles at a falling edge.
	task ev(input logic l, input int k);
		@(posedge mclk);
		ev_req <= l;
		repeat (k) @(posedge mclk);
		@(negedge mclk);
	endtask

	task cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
		wr(OFS_MODE_CTRL, b);
		wr(OFS_EVENT_CTRL, e);
		wr(OFS_MAIN_CTRL, a);
	endtask

	task t_regs;
		rd(OFS_MAIN_CTRL, 8'h00);
		rd(OFS_MODE_CTRL, 8'h00);
		rd(OFS_EVENT_CTRL, 8'h00);
		wr(OFS_MODE_CTRL, 8'hff);
		wr(OFS_EVENT_CTRL, 8'hff);
		wr(OFS_MAIN_CTRL, 8'hfe);
		wr(4'h2, 8'hff);
		rd(OFS_MAIN_CTRL, 8'h56);
		rd(OFS_MODE_CTRL, 8'h77);
		rd(OFS_EVENT_CTRL, 8'h51);
		rd(4'h2, 8'h00);
		cfg(8'h00, 8'h00, 8'h00);
	endtask

	// Rows: control A, control B, event control, capture count after rise, fall, rise, fall.
	task t_edges;
		logic [39:0] row[10] = '{40'h01_02_01_1122, 40'h01_02_11_0112, 40'h01_03_01_1122,
			40'h01_04_01_0112, 40'h01_04_11_1122, 40'h01_05_01_0011, 40'h00_02_01_0000,
			40'h01_02_00_0000, 40'h01_00_01_0000, 40'h01_07_01_0000};
		for (int i = 0; i < 10; i++) begin
			cfg(row[i][39:32], row[i][31:24], row[i][23:16]);
			n = caps;
			for (int s = 0; s < 4; s++) begin
				ev(s[0] == 1'b0, 6);
				check(16'(caps - n), {12'h000, row[i][15-4*s -: 4]});
			end
			wr(OFS_MAIN_CTRL, 8'h00);
		end
	endtask

	task t_filter;
		cfg(8'h01, 8'h02, 8'h41);
		n = caps;
		ev(1'b1, 2);
		ev(1'b0, 8);
		check(16'(caps - n), 16'h0000);
		ev(1'b1, 8);
		check(16'(caps - n), 16'h0001);
		ev(1'b0, 8);
		cfg(8'h00, 8'h02, 8'h00);
	endtask

	// Both edge settings: the selected edge starts the counter, the other stops it.
	task t_timeout;
		for (int e = 0; e < 2; e++) begin
			cfg(8'h01, 8'h01, {3'h0, e[0], 4'h1});
			ev(1'b1, 4);
			check({15'h0, running}, {15'h0, ~e[0]});
			rd(OFS_STATUS, {7'h00, ~e[0]});
			ev(1'b0, 4);
			check({15'h0, running}, {15'h0, e[0]});
			wr(OFS_MAIN_CTRL, 8'h00);
		end
	endtask

	// Two rising events ten cycles apart; the capture holds the count since the restart.
	task t_period;
		cfg(8'h01, 8'h03, 8'h01);
		ev(1'b1, 4);
		ev(1'b0, 4);
		ev(1'b1, 4);
		check(capture_value, 16'h0009);
		ev(1'b0, 4);
		cfg(8'h00, 8'h00, 8'h00);
	endtask

	task t_single;
		top_value <= 16'h0010;
		for (int a = 0; a < 2; a++) begin
			cfg(8'h01, {1'b0, a[0], 6'h36}, 8'h01);
			n = caps;
			repeat (2) @(negedge mclk);
			check({15'h0, pin_out}, 16'h0000);
			ev(1'b1, 5);
			check({14'h0, running, pin_out}, 16'h0003);
			ev(1'b0, 30);
			check({14'h0, running, pin_out}, 16'h0000);
			check(16'(caps - n), 16'h0001);
			wr(OFS_MAIN_CTRL, 8'h00);
		end
		top_value <= 16'hffff;
	endtask

	task t_wave;
		for (int l = 0; l < 2; l++) begin
			cfg(8'h01, {2'h0, l[0], 5'h10}, 8'h00);
			port_out_value <= ~l[0];
			repeat (3) @(negedge mclk);
			check({14'h0, pin_override, pin_out}, {14'h0, 1'b1, l[0]});
			wr(OFS_MODE_CTRL, {2'h0, l[0], 5'h00});
			repeat (3) @(negedge mclk);
			check({15'h0, pin_out}, {15'h0, ~l[0]});
			wr(OFS_MAIN_CTRL, 8'h00);
		end
	endtask

	// Rows: control A, standby level, expected count growth over ten cycles.
	task t_clock;
		logic [15:0] row[7] = '{16'h05_0_0, 16'h03_0_5, 16'h01_0_a, 16'h07_0_5, 16'h01_1_0,
			16'h41_1_a, 16'h07_1_5};
		tick_req <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			standby_sleep <= row[i][4];
			cfg(row[i][15:8], 8'h00, 8'h00);
			repeat (4) @(negedge mclk);
			c0 = count_value;
			repeat (10) @(negedge mclk);
			check(count_value - c0, {12'h000, row[i][3:0]});
			wr(OFS_MAIN_CTRL, 8'h00);
		end
		standby_sleep <= 1'b0;
		wr(OFS_MAIN_CTRL, 8'h17);
		repeat (20) @(posedge mclk);
		restart_req <= 1'b1;
		@(posedge mclk);
		restart_req <= 1'b0;
		repeat (3) @(negedge mclk);
		check({15'h0, count_value < 16'h0004}, 16'h0001);
		wr(OFS_MAIN_CTRL, 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_edges;
		t_filter;
		t_timeout;
		t_period;
		t_single;
		t_wave;
		t_clock;
		end_of_test;
	end
endmodule
